// [hdl/srs_pkg.sv]
// Notes on behaviour
// (RL1) Load special register from work register, one cycle
// (RL2) Read special register into work register, flags kept
// (RL3) File minus work: zero, digit carry, carry
// (RL4) Dest 0 to work register, 1 to file
// (RL5) Immediate minus work register into work register
// (RL6) Halt clears watchdog counter, divider, then halts
// (RL7) Halt sets timeout_flag_n, clears powerdown_flag_n only
// (RL8) Carry means no borrow; zero on zero result
package srs_pkg;

  // Register byte offsets on the AXI4-Lite port
  localparam logic [7:0] INSTR_OFFSET    = 8'h00;  // Write launches one instruction
  localparam logic [7:0] WORK_OFFSET     = 8'h04;  // Work register
  localparam logic [7:0] STATUS_OFFSET   = 8'h08;  // Flags and halt state
  localparam logic [7:0] FILE_PTR_OFFSET = 8'h0C;  // Index for the file and special windows
  localparam logic [7:0] FILE_DATA_OFFSET = 8'h10; // File register at the index
  localparam logic [7:0] SPEC_DATA_OFFSET = 8'h14; // Special page register at index[4:0]

  // Status register bit positions
  localparam int CARRY_BIT     = 0;
  localparam int DCARRY_BIT    = 1;
  localparam int ZERO_BIT      = 2;
  localparam int PD_N_BIT      = 3;
  localparam int TO_N_BIT      = 4;
  localparam int HALTED_BIT    = 5;

  // Values after reset
  localparam logic [7:0] WORK_RESET  = 8'h00;
  localparam logic       TO_N_RESET  = 1'b1;
  localparam logic       PD_N_RESET  = 1'b1;

  // Storage sizes
  localparam int FILE_DEPTH = 128;
  localparam int SPEC_DEPTH = 32;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Instruction opcodes
  typedef enum logic [2:0] {
    SRS_OP_NOP       = 3'h0,
    SRS_OP_LOAD_SPEC = 3'h1,
    SRS_OP_READ_SPEC = 3'h2,
    SRS_OP_SUB_FILE  = 3'h3,
    SRS_OP_SUB_IMM   = 3'h4,
    SRS_OP_HALT      = 3'h5
  } srs_op_e;

  // Instruction word as written to INSTR_OFFSET
  typedef struct packed {
    logic [7:0]  unused_hi;  // Bits 31:24
    logic [7:0]  imm;        // Bits 23:16 immediate
    logic        unused_a;   // Bit 15
    logic [6:0]  addr;       // Bits 14:8 file address, special index in [4:0]
    logic [3:0]  unused_b;   // Bits 7:4
    logic        dest;       // Bit 3 destination select
    srs_op_e     op;         // Bits 2:0 opcode
  } srs_instr_s;

  // Core run state
  typedef enum logic {
    SRS_RUN,
    SRS_HALT
  } srs_state_e;

endpackage

// [hdl/srs_sub_unit.sv]
`timescale 1ns/10ps
// Two's complement subtract minuend - subtrahend with flags
module srs_sub_unit #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] minuend_i,     // File value or immediate
  input  wire logic [WIDTH-1:0] subtrahend_i,  // Work register
  output logic      [WIDTH-1:0] diff_o,        // Result
  output logic                  zero_o,        // Result is zero
  output logic                  dcarry_o,      // No borrow out of low nibble
  output logic                  carry_o        // No borrow out of top bit
);

  logic [WIDTH:0] full_sum;  // Add of inverse plus one, carry on top
  logic [4:0]     nib_sum;   // Low nibble add for the digit carry

  // Adding the inverse plus one gives carry set exactly when no borrow
  always_comb begin
    full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {{WIDTH{1'b0}}, 1'b1};  // RL8
    nib_sum  = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]} + 5'h01;
    diff_o   = full_sum[WIDTH-1:0];
    carry_o  = full_sum[WIDTH];  // RL8
    dcarry_o = nib_sum[4];
    zero_o   = (full_sum[WIDTH-1:0] == '0);  // RL8
  end

endmodule // srs_sub_unit

// [hdl/srs_top.sv]
`timescale 1ns/10ps
// Executor for special register moves, subtracts and halt
module srs_top
  import srs_pkg::*;
(
  input  wire logic        ref_clk_i,           // 100 MHz clock
  input  wire logic        rst_i,               // Async reset, active high
  input  wire logic        wake_i,              // Leaves halt mode
  output logic             watchdog_clear_o,    // Clears watchdog counter and divider
  output logic             halted_o,            // Core is in halt mode
  output logic             timeout_flag_n_o,    // Time-out flag, active low
  output logic             powerdown_flag_n_o,  // Power-down flag, active low
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Write channel holding registers
  logic        aw_held;   // Write address taken, not yet used
  logic [7:0]  aw_addr;   // Held write address
  logic        w_held;    // Write data taken, not yet used
  logic [31:0] w_data;    // Held write data
  logic [3:0]  w_strb;    // Held byte strobes

  // Architectural state
  logic [7:0]  work_register;                       // Working register
  logic        carry_flag;                          // Carry, no borrow
  logic        digit_carry_flag;                    // Nibble carry
  logic        zero_flag;                           // Zero result
  logic [7:0]  file_regs [FILE_DEPTH];              // File register page
  logic [7:0]  special_page_register [SPEC_DEPTH];  // Special page
  logic [6:0]  file_ptr;                            // Window index
  srs_state_e  run_state;                           // Run or halt

  // Decode and datapath
  logic        do_write;   // Both halves present, response slot free
  logic        wr_any;     // At least one lane strobed
  logic        wr_hit;     // Write address is mapped
  logic        exec;       // Instruction executes this cycle
  srs_instr_s  instr;      // Instruction fields
  logic [4:0]  spec_idx;   // Special page index from operand
  logic [7:0]  sub_a;      // Minuend
  logic [7:0]  sub_diff;   // Difference
  logic        sub_zero;
  logic        sub_dcarry;
  logic        sub_carry;
  logic        is_sub;     // Either subtract opcode
  logic        rd_hit;     // Read address is mapped
  logic [31:0] rd_word;    // Read mux result

  // Channels are refused while a response is still pending
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_any   = |w_strb;
  assign instr    = srs_instr_s'(w_data);
  assign spec_idx = instr.addr[4:0];

  // Write address decode
  always_comb begin
    unique case (aw_addr)
      INSTR_OFFSET, WORK_OFFSET, STATUS_OFFSET,
      FILE_PTR_OFFSET, FILE_DATA_OFFSET, SPEC_DATA_OFFSET: wr_hit = 1'b1;
      default:                                             wr_hit = 1'b0;
    endcase
  end

  // A halted core ignores instructions until woken
  assign exec = do_write && wr_any && wr_hit && (aw_addr == INSTR_OFFSET) && (run_state == SRS_RUN);

  // Immediate subtract uses the operand, the other uses the file value
  assign is_sub = (instr.op == SRS_OP_SUB_FILE) || (instr.op == SRS_OP_SUB_IMM);
  assign sub_a  = (instr.op == SRS_OP_SUB_IMM) ? instr.imm : file_regs[instr.addr];  // RL3 RL5

  srs_sub_unit #(
    .WIDTH (8)
  ) u_sub (
    .minuend_i    (sub_a),
    .subtrahend_i (work_register),
    .diff_o       (sub_diff),
    .zero_o       (sub_zero),
    .dcarry_o     (sub_dcarry),
    .carry_o      (sub_carry)
  );

  // Address and data halves are taken in either order
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, one per completed write
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read mux over mapped registers, unused bits read as zero
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    unique case (s_axi_araddr)
      WORK_OFFSET:      rd_word[7:0] = work_register;
      STATUS_OFFSET: begin
        rd_word[CARRY_BIT]  = carry_flag;
        rd_word[DCARRY_BIT] = digit_carry_flag;
        rd_word[ZERO_BIT]   = zero_flag;
        rd_word[PD_N_BIT]   = powerdown_flag_n_o;
        rd_word[TO_N_BIT]   = timeout_flag_n_o;
        rd_word[HALTED_BIT] = (run_state == SRS_HALT);
      end
      FILE_PTR_OFFSET:  rd_word[6:0] = file_ptr;
      FILE_DATA_OFFSET: rd_word[7:0] = file_regs[file_ptr];
      SPEC_DATA_OFFSET: rd_word[7:0] = special_page_register[file_ptr[4:0]];
      INSTR_OFFSET:     rd_word = 32'h00000000;  // Write-only, reads zero
      default:          rd_hit = 1'b0;
    endcase
  end

  // Read channel, data captured on the address handshake
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Work register: software, special read and subtract results
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      work_register <= WORK_RESET;
    end else if (exec) begin
      unique case (instr.op)
        SRS_OP_READ_SPEC: work_register <= special_page_register[spec_idx];  // RL2
        SRS_OP_SUB_FILE: begin
          if (!instr.dest) begin
            work_register <= sub_diff;  // RL4
          end
        end
        SRS_OP_SUB_IMM:   work_register <= sub_diff;  // RL5
        default:          work_register <= work_register;
      endcase
    end else if (do_write && wr_any && aw_addr == WORK_OFFSET) begin
      work_register <= w_data[7:0];
    end
  end

  // Arithmetic flags; moves and halt leave them alone
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      carry_flag       <= 1'b0;
      digit_carry_flag <= 1'b0;
      zero_flag        <= 1'b0;
    end else if (exec && is_sub) begin
      carry_flag       <= sub_carry;   // RL3 RL5 RL8
      digit_carry_flag <= sub_dcarry;  // RL3 RL5
      zero_flag        <= sub_zero;    // RL8
    end else if (do_write && wr_any && aw_addr == STATUS_OFFSET) begin
      carry_flag       <= w_data[CARRY_BIT];
      digit_carry_flag <= w_data[DCARRY_BIT];
      zero_flag        <= w_data[ZERO_BIT];
    end
  end

  // File page: write-back subtract or software window
  always_ff @(posedge ref_clk_i) begin
    if (exec && instr.op == SRS_OP_SUB_FILE && instr.dest) begin
      file_regs[instr.addr] <= sub_diff;  // RL4
    end else if (do_write && wr_any && aw_addr == FILE_DATA_OFFSET) begin
      file_regs[file_ptr] <= w_data[7:0];
    end
  end

  // Special page: loaded from the work register or software window
  always_ff @(posedge ref_clk_i) begin
    if (exec && instr.op == SRS_OP_LOAD_SPEC) begin
      special_page_register[spec_idx] <= work_register;  // RL1
    end else if (do_write && wr_any && aw_addr == SPEC_DATA_OFFSET) begin
      special_page_register[file_ptr[4:0]] <= w_data[7:0];
    end
  end

  // Window index
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      file_ptr <= 7'h00;
    end else if (do_write && wr_any && aw_addr == FILE_PTR_OFFSET) begin
      file_ptr <= w_data[6:0];
    end
  end

  // Halt: clear pulse and state change land on the same edge
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_state        <= SRS_RUN;
      watchdog_clear_o <= 1'b0;
    end else begin
      watchdog_clear_o <= exec && instr.op == SRS_OP_HALT;  // RL6
      unique case (run_state)
        SRS_RUN: begin
          if (exec && instr.op == SRS_OP_HALT) begin
            run_state <= SRS_HALT;  // RL6
          end
        end
        SRS_HALT: begin
          if (wake_i) begin
            run_state <= SRS_RUN;
          end
        end
      endcase
    end
  end

  assign halted_o = (run_state == SRS_HALT);

  // Time-out and power-down flags change only on halt
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timeout_flag_n_o   <= TO_N_RESET;
      powerdown_flag_n_o <= PD_N_RESET;
    end else if (exec && instr.op == SRS_OP_HALT) begin
      timeout_flag_n_o   <= 1'b1;  // RL7
      powerdown_flag_n_o <= 1'b0;  // RL7
    end
  end

endmodule // srs_top

// [tb/srs_top_asserts.sv]
`timescale 1ns/10ps
// Halt side effects and execute timing seen at the ports
module srs_top_asserts
  import srs_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        wake_i,
  input  wire logic        watchdog_clear_o,
  input  wire logic        halted_o,
  input  wire logic        timeout_flag_n_o,
  input  wire logic        powerdown_flag_n_o,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid
);
  logic [7:0] aw_q;    // Address of the last write
  logic [2:0] op_q;    // Opcode of the last write data
  logic       en_q;    // Last write had byte enables
  logic       is_halt; // Pending write is a halt
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Halves are captured apart, since they may arrive apart
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_q <= 8'hFF;
      op_q <= 3'h0;
      en_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        op_q <= s_axi_wdata[2:0];
        en_q <= |s_axi_wstrb;
      end
    end
  end
  assign is_halt = (aw_q == INSTR_OFFSET) && en_q && (op_q == SRS_OP_HALT);
  a_halt_clear: assert property (
    $rose(s_axi_bvalid) && is_halt && !$past(halted_o) |-> watchdog_clear_o)
    else $error("halt did not clear watchdog");
  a_halt_enter: assert property (
    $rose(s_axi_bvalid) && is_halt && !$past(halted_o) |-> halted_o)
    else $error("halt did not enter halt mode");
  a_halt_flags: assert property (
    $rose(s_axi_bvalid) && is_halt && !$past(halted_o) |-> timeout_flag_n_o && !powerdown_flag_n_o)
    else $error("halt flags wrong");
  a_clear_pulse: assert property (
    watchdog_clear_o |=> !watchdog_clear_o)
    else $error("watchdog clear longer than one cycle");
  a_clear_cause: assert property (
    watchdog_clear_o |-> $rose(s_axi_bvalid) && is_halt && !$past(halted_o))
    else $error("watchdog clear without halt");
  a_flags_kept: assert property (
    !($rose(s_axi_bvalid) && is_halt) |-> $stable(timeout_flag_n_o) && $stable(powerdown_flag_n_o))
    else $error("flags changed without halt");
  a_halt_hold: assert property (
    halted_o && !wake_i |=> halted_o)
    else $error("halt left without wake");
  // Halves are held one cycle before the execute edge raises the response
  a_one_cycle: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered in time");
endmodule // srs_top_asserts

// [tb/srs_top_tb_top.sv]
`timescale 1ns/10ps
// Register driven bench for the executor
module srs_top_tb_top
  import srs_pkg::*;
;
  logic        ref_clk_i = 1'b0, rst_i = 1'b1, wake_i = 1'b0;
  logic        watchdog_clear_o, halted_o, timeout_flag_n_o, powerdown_flag_n_o;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures = 0, num_checks = 0;
  int          clr_cnt = 0;  // Clear pulses seen at the port
  // Minuend and work value for each subtract case
  logic [7:0]  sm [6] = '{8'h06, 8'h05, 8'hFF, 8'h06, 8'h10, 8'h00};
  logic [7:0]  sw [6] = '{8'h05, 8'h06, 8'h00, 8'h06, 8'h01, 8'hFF};

  srs_top dut (.ref_clk_i, .rst_i, .wake_i, .watchdog_clear_o, .halted_o, .timeout_flag_n_o,
    .powerdown_flag_n_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;

  // Count watchdog clear pulses, sampled before the edge updates them
  always @(posedge ref_clk_i) begin
    if (watchdog_clear_o === 1'b1) clr_cnt <= clr_cnt + 1;
  end

  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Instruction word builder
  function automatic logic [31:0] ins(srs_op_e op, logic d, logic [6:0] a, logic [7:0] i);
    return {8'h00, i, 1'b0, a, 4'h0, d, op};
  endfunction

  // Write with address and data offered together; each half dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    // One idle edge so the next call never re-raises bready in this step
    @(posedge ref_clk_i);
  endtask

  // Read and compare data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    // One idle edge so the next call never re-raises rready in this step
    @(posedge ref_clk_i);
  endtask

  // Reset values and an unmapped place
  task automatic t_reset;
    rd(WORK_OFFSET, 32'h0, RESP_OKAY);
    rd(STATUS_OFFSET, 32'h18, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h1, RESP_SLVERR);
  endtask

  // Load top special index; carry preset to see it kept
  task automatic t_load;
    wr(STATUS_OFFSET, 32'h1, RESP_OKAY);
    wr(WORK_OFFSET, 32'hAA, RESP_OKAY);
    wr(FILE_PTR_OFFSET, 32'h1F, RESP_OKAY);
    wr(INSTR_OFFSET, ins(SRS_OP_LOAD_SPEC, 1'b0, 7'h1F, 8'h0), RESP_OKAY);
    rd(SPEC_DATA_OFFSET, 32'hAA, RESP_OKAY);
    rd(STATUS_OFFSET, 32'h19, RESP_OKAY);
  endtask

  // Read special back into work
  task automatic t_read;
    wr(SPEC_DATA_OFFSET, 32'h55, RESP_OKAY);
    wr(WORK_OFFSET, 32'h0, RESP_OKAY);
    wr(INSTR_OFFSET, ins(SRS_OP_READ_SPEC, 1'b0, 7'h1F, 8'h0), RESP_OKAY);
    rd(WORK_OFFSET, 32'h55, RESP_OKAY);
    rd(SPEC_DATA_OFFSET, 32'h55, RESP_OKAY);
    rd(STATUS_OFFSET, 32'h19, RESP_OKAY);
  endtask

  // Subtract table at file address 127; first two cases use the file
  // The unused source holds the inverse, so a wrong minuend select shows
  task automatic t_sub;
    logic [7:0] df;
    logic [7:0] ot;
    logic [2:0] fl;
    wr(FILE_PTR_OFFSET, 32'h7F, RESP_OKAY);
    for (int i = 0; i < 6; i++) begin
      df = sm[i] - sw[i];
      ot = ~sm[i];
      fl = {df == 8'h00, sm[i][3:0] >= sw[i][3:0], sm[i] >= sw[i]};
      wr(FILE_DATA_OFFSET, {24'h0, i < 2 ? sm[i] : ot}, RESP_OKAY);
      wr(WORK_OFFSET, {24'h0, sw[i]}, RESP_OKAY);
      wr(STATUS_OFFSET, 32'h0, RESP_OKAY);
      wr(INSTR_OFFSET, ins(i < 2 ? SRS_OP_SUB_FILE : SRS_OP_SUB_IMM, i == 0, 7'h7F, i < 2 ? ot : sm[i]), RESP_OKAY);
      rd(WORK_OFFSET, {24'h0, i == 0 ? sw[i] : df}, RESP_OKAY);
      rd(FILE_DATA_OFFSET, {24'h0, i == 0 ? df : (i < 2 ? sm[i] : ot)}, RESP_OKAY);
      rd(STATUS_OFFSET, {27'h3, fl}, RESP_OKAY);
    end
  endtask

  // Halt, two refused instructions, then wake
  task automatic t_halt;
    wr(INSTR_OFFSET, ins(SRS_OP_HALT, 1'b0, 7'h0, 8'h0), RESP_OKAY);
    chk("halted", halted_o, 1'b1);
    chk("clear", clr_cnt, 32'h1);
    chk("to_n", timeout_flag_n_o, 1'b1);
    chk("pd_n", powerdown_flag_n_o, 1'b0);
    rd(STATUS_OFFSET, 32'h30, RESP_OKAY);
    wr(INSTR_OFFSET, ins(SRS_OP_SUB_IMM, 1'b0, 7'h0, 8'h20), RESP_OKAY);
    wr(INSTR_OFFSET, ins(SRS_OP_HALT, 1'b0, 7'h0, 8'h0), RESP_OKAY);
    chk("clear", clr_cnt, 32'h1);
    rd(WORK_OFFSET, 32'h1, RESP_OKAY);
    wake_i <= 1'b1;
    @(posedge ref_clk_i);
    wake_i <= 1'b0;
    @(posedge ref_clk_i);
    chk("halted", halted_o, 1'b0);
    // Unknown opcode does nothing; then the core executes again
    wr(INSTR_OFFSET, 32'h00200007, RESP_OKAY);
    rd(WORK_OFFSET, 32'h1, RESP_OKAY);
    wr(INSTR_OFFSET, ins(SRS_OP_SUB_IMM, 1'b0, 7'h0, 8'h20), RESP_OKAY);
    rd(WORK_OFFSET, 32'h1F, RESP_OKAY);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset;
    t_load;
    t_read;
    t_sub;
    t_halt;
    finish_test;
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #200us;
    failures++;
    finish_test;
  end
endmodule // srs_top_tb_top

bind srs_top srs_top_asserts u_chk (.ref_clk_i, .rst_i, .wake_i, .watchdog_clear_o, .halted_o,
  .timeout_flag_n_o, .powerdown_flag_n_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid);
